//--- verilog/input_pin_config_registers.sv
// configuration bytes 14 to 19: input pulls and input polarity
// assumes a byte-wide write/read port from the serial-bus slave, on clk
`timescale 1ns/1ps

module input_pin_config_registers (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// byte access from the serial-bus slave
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	output logic            rd_hit,
	// raw pins
	input  wire logic [5:0] enable_in,
	input  wire logic       power_good_powerdown_in,
	// pad pull controls
	output logic      [5:0] pull_up_en,
	output logic      [5:0] pull_down_en,
	output logic            pwrdn_pull_up_en,
	output logic            pwrdn_pull_down_en,
	// decoded controls
	output logic      [5:0] output_enable,
	output logic            powerdown
);
	import pin_cfg_pkg::*;

	logic [7:0] pull_lower_reg, pull_lower_next;
	logic [7:0] pull_upper_reg, pull_upper_next;
	logic [7:0] pd_pull_reg,    pd_pull_next;
	logic [7:0] en_pol_reg,     en_pol_next;
	logic [7:0] pd_pol_reg,     pd_pol_next;
	logic [7:0] rd_data_next;
	logic       rd_hit_next;
	logic [1:0] pull_sel [6];
	logic [5:0] active_high;

	// masked byte update; reserved bits stay zero
	function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] mask,
		input logic [7:0] d, input logic hit);
		upd = hit ? (d & mask) : old;
	endfunction

	// pull-up present for codes 10 and 11
	function automatic logic has_pull_up(input logic [1:0] sel);
		has_pull_up = sel == PULL_UP || sel == PULL_BOTH;
	endfunction

	// pull-down present for codes 01 and 11
	function automatic logic has_pull_down(input logic [1:0] sel);
		has_pull_down = sel == PULL_DOWN || sel == PULL_BOTH;
	endfunction

	always_comb begin
		pull_lower_next = upd(pull_lower_reg, MASK_ENABLE_PULL, wr_data, wr_en && addr == OFS_ENABLE_PULL_LOWER);
		pull_upper_next = upd(pull_upper_reg, MASK_ENABLE_PULL, wr_data, wr_en && addr == OFS_ENABLE_PULL_UPPER);
		pd_pull_next    = upd(pd_pull_reg, MASK_PWRDN_PULL, wr_data, wr_en && addr == OFS_POWERDOWN_PULL);
		en_pol_next     = upd(en_pol_reg, MASK_ENABLE_POL, wr_data, wr_en && addr == OFS_ENABLE_POLARITY);
		pd_pol_next     = upd(pd_pol_reg, MASK_PWRDN_POL, wr_data, wr_en && addr == OFS_POWERDOWN_POL);
		rd_hit_next     = 1'b1;
		// byte 17 reads zero and stores nothing
		unique case (addr)
			OFS_ENABLE_PULL_LOWER: rd_data_next = pull_lower_reg;
			OFS_ENABLE_PULL_UPPER: rd_data_next = pull_upper_reg;
			OFS_POWERDOWN_PULL:    rd_data_next = pd_pull_reg;
			OFS_RESERVED_17:       rd_data_next = 8'h00;
			OFS_ENABLE_POLARITY:   rd_data_next = en_pol_reg;
			OFS_POWERDOWN_POL:     rd_data_next = pd_pol_reg;
			default: begin
				rd_data_next = 8'h00;
				rd_hit_next  = 1'b0;
			end
		endcase
		// idle cycles keep the last read byte for a slow host
		if (!rd_en) begin
			rd_data_next = rd_data;
			rd_hit_next  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pull_lower_reg <= RST_ENABLE_PULL;
			pull_upper_reg <= RST_ENABLE_PULL;
			pd_pull_reg    <= RST_PWRDN_PULL;
			en_pol_reg     <= RST_ENABLE_POL;
			pd_pol_reg     <= RST_PWRDN_POL;
			rd_data        <= 8'h00;
			rd_hit         <= 1'b0;
		end else begin
			pull_lower_reg <= pull_lower_next;
			pull_upper_reg <= pull_upper_next;
			pd_pull_reg    <= pd_pull_next;
			en_pol_reg     <= en_pol_next;
			pd_pol_reg     <= pd_pol_next;
			rd_data        <= rd_data_next;
			rd_hit         <= rd_hit_next;
		end
	end

	assign pull_sel[0] = pull_lower_reg[PULL_LSB_EN0 +: PULL_W];
	assign pull_sel[1] = pull_lower_reg[PULL_LSB_EN1 +: PULL_W];
	assign pull_sel[2] = pull_lower_reg[PULL_LSB_EN2 +: PULL_W];
	assign pull_sel[3] = pull_upper_reg[PULL_LSB_EN3 +: PULL_W];
	assign pull_sel[4] = pull_upper_reg[PULL_LSB_EN4 +: PULL_W];
	assign pull_sel[5] = pull_upper_reg[PULL_LSB_EN5 +: PULL_W];
	assign active_high = {en_pol_reg[POL_BIT_EN5], en_pol_reg[POL_BIT_EN4], en_pol_reg[POL_BIT_EN3],
		en_pol_reg[POL_BIT_EN2], en_pol_reg[POL_BIT_EN1], en_pol_reg[POL_BIT_EN0]};

	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pull_up_en[i]   = has_pull_up(pull_sel[i]);
			pull_down_en[i] = has_pull_down(pull_sel[i]);
		end
		pwrdn_pull_up_en   = has_pull_up(pd_pull_reg[PULL_LSB_PWRDN +: PULL_W]);
		pwrdn_pull_down_en = has_pull_down(pd_pull_reg[PULL_LSB_PWRDN +: PULL_W]);
		output_enable = ~(enable_in ^ active_high);
		powerdown = ~(power_good_powerdown_in ^ pd_pol_reg[POL_BIT_PWRDN]);
	end

	a_reset_pulldown: assert property (@(posedge clk) !reset_n |=> pull_down_en == 6'h3F && pull_up_en == 6'h00)
		else $error("enable pulls not pull-down after reset");
	a_reset_pdpullup: assert property (@(posedge clk) !reset_n |=> pwrdn_pull_up_en && !pwrdn_pull_down_en)
		else $error("power-down pull not pull-up after reset");
	a_reset_polarity: assert property (@(posedge clk) !reset_n |=> en_pol_reg == 8'h00 && !pd_pol_reg[0])
		else $error("polarity not zero after reset");
	a_reset_lower: assert property (@(posedge clk) !reset_n |=> pull_lower_reg == RST_ENABLE_PULL)
		else $error("byte 14 not pull-down after reset");

	a_enable_decode: assert property (@(posedge clk) disable iff (!reset_n)
		output_enable[5] == (enable_in[5] == en_pol_reg[7])) else $error("enable 5 polarity wrong");
	a_enable_lower: assert property (@(posedge clk) disable iff (!reset_n)
		output_enable[2:0] == {enable_in[2] == en_pol_reg[POL_BIT_EN2],
		enable_in[1] == en_pol_reg[POL_BIT_EN1], enable_in[0] == en_pol_reg[POL_BIT_EN0]})
		else $error("enables 0 to 2 polarity wrong");
	a_enable_middle: assert property (@(posedge clk) disable iff (!reset_n)
		output_enable[4:3] == {enable_in[4] == en_pol_reg[POL_BIT_EN4], enable_in[3] == en_pol_reg[POL_BIT_EN3]})
		else $error("enables 3 and 4 polarity wrong");
	a_powerdown_decode: assert property (@(posedge clk) disable iff (!reset_n)
		powerdown == (power_good_powerdown_in == pd_pol_reg[0])) else $error("power-down polarity wrong");
	a_pull_both: assert property (@(posedge clk) disable iff (!reset_n)
		pull_sel[0] == PULL_BOTH |-> pull_up_en[0] && pull_down_en[0]) else $error("both-pull decode wrong");
	a_pull_none: assert property (@(posedge clk) disable iff (!reset_n)
		pull_sel[3] == PULL_NONE |-> !pull_up_en[3] && !pull_down_en[3]) else $error("no-pull decode wrong");
	a_pull_up_only: assert property (@(posedge clk) disable iff (!reset_n)
		pull_sel[4] == PULL_UP |-> pull_up_en[4] && !pull_down_en[4]) else $error("pull-up decode wrong");
	a_pull_down_only: assert property (@(posedge clk) disable iff (!reset_n)
		pd_pull_reg[PULL_LSB_PWRDN +: PULL_W] == PULL_DOWN |-> pwrdn_pull_down_en && !pwrdn_pull_up_en)
		else $error("pull-down decode wrong");

	a_reserved_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		(en_pol_reg & ~MASK_ENABLE_POL) == 8'h00 && pd_pol_reg[7:1] == 7'h00) else $error("reserved bit set");
	a_pull_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		(pull_upper_reg & ~MASK_ENABLE_PULL) == 8'h00 && (pd_pull_reg & ~MASK_PWRDN_PULL) == 8'h00)
		else $error("reserved pull bit set");

	a_write_upper: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && addr == OFS_ENABLE_PULL_UPPER |=> pull_sel[5] == $past(wr_data[7:6])) else $error("byte 15 write lost");
	a_write_lower: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && addr == OFS_ENABLE_PULL_LOWER |=> pull_sel[2] == $past(wr_data[7:6])) else $error("byte 14 write lost");
	a_write_pdpull: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && addr == OFS_POWERDOWN_PULL |=> pd_pull_reg == ($past(wr_data) & MASK_PWRDN_PULL))
		else $error("byte 16 write lost");
	a_write_enpol: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && addr == OFS_ENABLE_POLARITY |=> en_pol_reg == ($past(wr_data) & MASK_ENABLE_POL))
		else $error("byte 18 write lost");
	a_write_pdpol: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && addr == OFS_POWERDOWN_POL |=> pd_pol_reg == ($past(wr_data) & MASK_PWRDN_POL))
		else $error("byte 19 write lost");

	a_byte17_read: assert property (@(posedge clk) disable iff (!reset_n)
		rd_en && addr == OFS_RESERVED_17 |=> rd_data == 8'h00 && rd_hit) else $error("byte 17 not zero");
	a_read_upper: assert property (@(posedge clk) disable iff (!reset_n)
		rd_en && addr == OFS_ENABLE_PULL_UPPER |=> rd_data == $past(pull_upper_reg) && rd_hit)
		else $error("byte 15 read wrong");
	a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
		rd_en && addr > OFS_POWERDOWN_POL |=> rd_data == 8'h00 && !rd_hit) else $error("unmapped read answered");
endmodule

//--- verilog/pin_cfg_pkg.sv
// constants for the input pin configuration byte bank
// shared by the bank and its bench; no clock or reset here
package pin_cfg_pkg;
	// byte addresses within the configuration space
	localparam logic [7:0] OFS_ENABLE_PULL_LOWER = 8'h0E;
	localparam logic [7:0] OFS_ENABLE_PULL_UPPER = 8'h0F;
	localparam logic [7:0] OFS_POWERDOWN_PULL    = 8'h10;
	localparam logic [7:0] OFS_RESERVED_17       = 8'h11;
	localparam logic [7:0] OFS_ENABLE_POLARITY   = 8'h12;
	localparam logic [7:0] OFS_POWERDOWN_POL     = 8'h13;

	// pull field encoding
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP   = 2'h2;
	localparam logic [1:0] PULL_BOTH = 2'h3;

	// field positions: lsb of each two-bit pull field, bit of each polarity flag
	localparam int PULL_W         = 2;
	localparam int PULL_LSB_EN0   = 0;
	localparam int PULL_LSB_EN1   = 4;
	localparam int PULL_LSB_EN2   = 6;
	localparam int PULL_LSB_EN3   = 0;
	localparam int PULL_LSB_EN4   = 4;
	localparam int PULL_LSB_EN5   = 6;
	localparam int PULL_LSB_PWRDN = 0;
	localparam int POL_BIT_EN0    = 0;
	localparam int POL_BIT_EN1    = 2;
	localparam int POL_BIT_EN2    = 3;
	localparam int POL_BIT_EN3    = 4;
	localparam int POL_BIT_EN4    = 6;
	localparam int POL_BIT_EN5    = 7;
	localparam int POL_BIT_PWRDN  = 0;

	// writable bits of each byte; reserved bits hold zero
	localparam logic [7:0] MASK_ENABLE_PULL  = 8'hF3;
	localparam logic [7:0] MASK_PWRDN_PULL   = 8'h03;
	localparam logic [7:0] MASK_ENABLE_POL   = 8'hDD;
	localparam logic [7:0] MASK_PWRDN_POL    = 8'h01;

	// power-up values
	localparam logic [7:0] RST_ENABLE_PULL   = 8'h51;
	localparam logic [7:0] RST_PWRDN_PULL    = 8'h02;
	localparam logic [7:0] RST_ENABLE_POL    = 8'h00;
	localparam logic [7:0] RST_PWRDN_POL     = 8'h00;
endpackage

//--- dv/cfg_host.sv
// host model: single byte writes and reads into the pin config bank
// assumes the bank takes a strobe at each rising clk edge
`timescale 1ns/1ps
module cfg_host (
	// clock
	input  wire logic       clk,
	// byte access
	output logic            wr_en   = 1'b0,
	output logic            rd_en   = 1'b0,
	output logic      [7:0] addr    = 8'h00,
	output logic      [7:0] wr_data = 8'h00
);
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en   <= 1'b1;
		addr    <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en   <= 1'b0;
		addr    <= ~a;
		wr_data <= ~d;
	endtask
	task automatic read(input logic [7:0] a);
		@(posedge clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		addr  <= ~a;
	endtask
endmodule

//--- dv/input_pin_config_registers_bench.sv
// bench for the pin config bank: resets, scenarios, verdict
// assumes the host model drives the byte access port
`timescale 1ns/1ps
module input_pin_config_registers_bench;
	import pin_cfg_pkg::*;
	logic       clk = 1'b0, reset_n = 1'b0, pg = 1'b0, wr_en, rd_en, rd_hit, pu_p, pd_p, pdn;
	logic [5:0] en = 6'h00, pu, pd, oe;
	logic [7:0] addr, wr_data, rd_data;
	int         errors = 0, n_compared = 0;
	always #5 clk = ~clk;
	cfg_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
	input_pin_config_registers dut (.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit), .enable_in(en),
		.power_good_powerdown_in(pg), .pull_up_en(pu), .pull_down_en(pd), .pwrdn_pull_up_en(pu_p),
		.pwrdn_pull_down_en(pd_p), .output_enable(oe), .powerdown(pdn));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		host.read(a);
		#1;
		check(rd_data, exp);
		check({7'h00, rd_hit}, {7'h00, hit});
	endtask
	task automatic pins(input logic [5:0] e, input logic p);
		@(posedge clk);
		en <= e;
		pg <= p;
		#1;
	endtask
	task automatic t_reset;
		rd_chk(OFS_ENABLE_PULL_LOWER, 8'h51, 1'b1);
		rd_chk(OFS_ENABLE_PULL_UPPER, 8'h51, 1'b1);
		rd_chk(OFS_POWERDOWN_PULL, 8'h02, 1'b1);
		rd_chk(OFS_ENABLE_POLARITY, 8'h00, 1'b1);
		rd_chk(OFS_POWERDOWN_POL, 8'h00, 1'b1);
		check({pu, pu_p, pd_p}, 8'h02);
		check({2'b00, pd}, 8'h3F);
		check({2'b00, oe}, 8'h3F);
	endtask
	task automatic t_pull;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			host.write(OFS_ENABLE_PULL_UPPER, {c, c, 2'b11, c});
			host.write(OFS_ENABLE_PULL_LOWER, {~c, ~c, 2'b11, ~c});
			host.write(OFS_POWERDOWN_PULL, {6'h3F, c});
			rd_chk(OFS_ENABLE_PULL_UPPER, {c, c, 2'b00, c}, 1'b1);
			rd_chk(OFS_POWERDOWN_PULL, {6'h00, c}, 1'b1);
			rd_chk(OFS_ENABLE_PULL_LOWER, {~c, ~c, 2'b00, ~c}, 1'b1);
			check({2'b00, pu}, {2'b00, {3{c[1]}}, {3{~c[1]}}});
			check({2'b00, pd}, {2'b00, {3{c[0]}}, {3{~c[0]}}});
			check({6'h00, pu_p, pd_p}, {6'h00, c});
		end
	endtask
	task automatic t_pol;
		host.write(OFS_ENABLE_POLARITY, 8'hFF);
		rd_chk(OFS_ENABLE_POLARITY, 8'hDD, 1'b1);
		pins(6'h3F, 1'b0);
		check({2'b00, oe}, 8'h3F);
		host.write(OFS_ENABLE_POLARITY, 8'h91);
		pins(6'h00, 1'b0);
		check({2'b00, oe}, 8'h16);
	endtask
	task automatic t_pd;
		host.write(OFS_POWERDOWN_POL, 8'hFE);
		rd_chk(OFS_POWERDOWN_POL, 8'h00, 1'b1);
		check({7'h00, pdn}, 8'h01);
		host.write(OFS_POWERDOWN_POL, 8'h01);
		pins(6'h00, 1'b1);
		check({7'h00, pdn}, 8'h01);
		pins(6'h00, 1'b0);
		check({7'h00, pdn}, 8'h00);
		host.write(OFS_RESERVED_17, 8'hFF);
		rd_chk(OFS_RESERVED_17, 8'h00, 1'b1);
		host.write(8'h20, 8'hFF);
		rd_chk(8'h20, 8'h00, 1'b0);
	endtask
	task automatic t_rerun;
		host.write(OFS_ENABLE_POLARITY, 8'hFF);
		host.write(OFS_ENABLE_PULL_UPPER, 8'h00);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		check({7'h00, pdn}, 8'h01);
	endtask
	task automatic stop_test;
		$display("errors %0d n_compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_pull();
		t_pol();
		t_pd();
		t_rerun();
		stop_test();
	end
endmodule
